//--- logic/low_power_tick_counter_map.vh
// register offsets, field positions and constants of the tick counter
`ifndef LOW_POWER_TICK_COUNTER_MAP_VH
`define LOW_POWER_TICK_COUNTER_MAP_VH

// trigger registers, write one to bit 0 to issue the task
`define OFS_GO_TRIGGER 12'h000
`define OFS_HALT_TRIGGER 12'h004
`define OFS_ZERO_TRIGGER 12'h008
`define OFS_PRESET_TRIGGER 12'h00c

// event flag registers
`define OFS_INCREMENT_FLAG 12'h100
`define OFS_WRAP_FLAG 12'h104
`define OFS_MATCH0_FLAG 12'h140
`define OFS_MATCH1_FLAG 12'h144
`define OFS_MATCH2_FLAG 12'h148
`define OFS_MATCH3_FLAG 12'h14c

// interrupt enables and event routing
`define OFS_IRQ_SET 12'h304
`define OFS_IRQ_CLEAR 12'h308
`define OFS_ROUTE 12'h340
`define OFS_ROUTE_SET 12'h344
`define OFS_ROUTE_CLEAR 12'h348

// count, divider and match values
`define OFS_COUNT 12'h504
`define OFS_DIVIDER 12'h508
`define OFS_MATCH0 12'h540
`define OFS_MATCH1 12'h544
`define OFS_MATCH2 12'h548
`define OFS_MATCH3 12'h54c

// event bit positions in enable and routing words
`define BIT_INCREMENT 0
`define BIT_WRAP 1
`define BIT_MATCH0 16

// reset values and special count values
`define RESET_WORD 32'h0000_0000
`define RESET_DIVIDER 12'h000
`define RESET_COUNT 24'h00_0000
`define NEAR_WRAP_VALUE 24'hff_fff0
`define LAST_COUNT 24'hff_ffff

// slow clock rate in hertz, increment rate is this over divider plus one
`define SLOW_CLOCK_HZ 32768

// wait states inserted on a count read, whole read is five bus cycles
`define COUNT_READ_STALL 2'h3

`endif

//--- logic/low_power_tick_counter.v
// low power tick counter: slow clock counting, match events, bus registers
//
// Function
// - 24-bit count with 12-bit reload divider
// - increment rate is slow clock over reload+1
// - divider reload writable only while stopped
// - start, clear, preset reload the divider countdown
// - count steps when countdown is zero, reload
// - increment event per step, disabled after reset
// - preset task loads count with near-wrap value
// - wrap event on all-ones to zero, default off
// - events neither routed nor interrupt-enabled never request fast clock
// - clear never causes a match on zero
// - start at count equal match gives no event
// - match event when count steps onto value
// - writing count plus two always matches later
// - old value above count plus two never fires
// - tasks wait for slow falling then rising edge
// - first increment follows start by slow edges
// - preset while slow clock idle requests the clock
// - bus count is sampled from counting register
// - count read stalls three cycles, five total
// - event bits: increment 0, wrap 1, matches 16-19
// - enable set and clear write ones, read enables
`timescale 1ns/100ps
`include "low_power_tick_counter_map.vh"

module low_power_tick_counter (
	input wire clock,
	input wire rst_n,
	input wire slow_clock,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output reg irq,
	output reg [5:0] event_out,
	output reg fast_clock_request,
	output reg slow_clock_request
);

	// task indices inside the pending vectors
	localparam TASK_GO = 0;
	localparam TASK_HALT = 1;
	localparam TASK_ZERO = 2;
	localparam TASK_PRESET = 3;

	// slow clock synchroniser, only lf_sync reads lf_meta
	reg lf_meta;
	reg lf_sync;
	reg lf_prev; // delayed copy for edge detection
	wire lf_rise;
	wire lf_fall;

	// counting state
	reg running; // counter started
	reg [11:0] reload; // divider reload value
	reg [11:0] countdown; // internal divider countdown
	reg [23:0] count; // count in the counting domain
	reg [23:0] match_value [0:3]; // match registers

	// task handshake toward the slow edges
	reg [3:0] pend; // task issued, not yet applied
	reg [3:0] fell; // falling slow edge seen since issue
	wire [3:0] apply; // task takes effect this cycle
	reg [3:0] trig; // tasks written this cycle

	// event state
	reg [5:0] flags; // sticky event flags
	reg [5:0] inten; // interrupt enables
	reg [5:0] route; // event routing mask
	wire [5:0] ev_raw; // events before gating
	wire [5:0] ev_fire; // events that latch a flag
	wire step; // count steps this cycle
	wire load; // count is loaded by a task this cycle
	wire [23:0] count_inc;

	// bus state
	reg [1:0] stall; // wait states spent on a count read
	wire access;
	wire setup;
	wire count_read;
	wire wr;
	reg [31:0] rd_word;
	reg [5:0] flag_wr_mask; // flags addressed by this write
	reg [5:0] flag_wr_set; // written value per addressed flag
	integer i;

	// pack six event bits out of a bus word
	function [5:0] pick_events;
		input [31:0] word;
		begin
			pick_events = {word[`BIT_MATCH0 + 3:`BIT_MATCH0],
				word[`BIT_WRAP], word[`BIT_INCREMENT]};
		end
	endfunction

	// spread six event bits into a bus word
	function [31:0] place_events;
		input [5:0] ev;
		begin
			place_events = `RESET_WORD;
			place_events[`BIT_INCREMENT] = ev[0];
			place_events[`BIT_WRAP] = ev[1];
			place_events[`BIT_MATCH0 + 3:`BIT_MATCH0] = ev[5:2];
		end
	endfunction

	// two flip-flops on the slow clock pin, then an edge register
	always @(posedge clock) begin
		if (!rst_n) begin
			lf_meta <= 1'b0;
			lf_sync <= 1'b0;
			lf_prev <= 1'b0;
		end else begin
			lf_meta <= slow_clock;
			lf_sync <= lf_meta;
			lf_prev <= lf_sync;
		end
	end

	// the slow rate is a one-cycle enable on each synchronised edge
	assign lf_rise = lf_sync & ~lf_prev;
	assign lf_fall = ~lf_sync & lf_prev;

	// bus phases
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign count_read = access & ~pwrite & (paddr == `OFS_COUNT);
	assign pready = ~count_read | (stall == `COUNT_READ_STALL);
	assign wr = access & pwrite & pready;

	// decode task triggers, bit 0 of the written word issues the task
	always @* begin
		trig = 4'h0;
		if (wr & pwdata[0]) begin
			if (paddr == `OFS_GO_TRIGGER) begin
				trig[TASK_GO] = 1'b1;
			end else if (paddr == `OFS_HALT_TRIGGER) begin
				trig[TASK_HALT] = 1'b1;
			end else if (paddr == `OFS_ZERO_TRIGGER) begin
				trig[TASK_ZERO] = 1'b1;
			end else if (paddr == `OFS_PRESET_TRIGGER) begin
				trig[TASK_PRESET] = 1'b1;
			end
		end
	end

	assign apply = {4{lf_rise}} & pend & fell;

	// task pending and edge tracking; a re-issued task waits again
	always @(posedge clock) begin
		if (!rst_n) begin
			pend <= 4'h0;
			fell <= 4'h0;
		end else begin
			// a new issue in the apply cycle survives the apply
			pend <= (pend & ~apply) | trig;
			fell <= (fell | ({4{lf_fall}} & pend)) & ~apply & ~trig;
		end
	end

	// the count is loaded by clear or preset, which beats a step
	assign load = apply[TASK_ZERO] | apply[TASK_PRESET];
	assign step = lf_rise & running & ~load & (countdown == 12'h000);
	assign count_inc = count + 24'h00_0001;

	// divider countdown and run state, updated on slow rising edges
	always @(posedge clock) begin
		if (!rst_n) begin
			running <= 1'b0;
			countdown <= `RESET_DIVIDER;
		end else begin
			// start wins if start and stop land on the same edge
			if (apply[TASK_GO]) begin
				running <= 1'b1;
			end else if (apply[TASK_HALT]) begin
				running <= 1'b0;
			end
			if (apply[TASK_GO] | load) begin
				countdown <= reload;
			end else if (lf_rise & running) begin
				if (countdown == 12'h000) begin
					countdown <= reload;
				end else begin
					countdown <= countdown - 12'h001;
				end
			end
		end
	end

	// the count itself
	always @(posedge clock) begin
		if (!rst_n) begin
			count <= `RESET_COUNT;
		end else if (apply[TASK_ZERO]) begin
			count <= `RESET_COUNT;
		end else if (apply[TASK_PRESET]) begin
			count <= `NEAR_WRAP_VALUE;
		end else if (step) begin
			count <= count_inc;
		end
	end

	assign ev_raw[0] = step;
	assign ev_raw[1] = step & (count == `LAST_COUNT);

	// matches are only checked on a step, never on a load or a start
	genvar m;
	generate
		for (m = 0; m < 4; m = m + 1) begin : match_cmp
			assign ev_raw[2 + m] = step & (count_inc == match_value[m]);
		end
	endgenerate

	// an event with neither routing nor interrupt enabled stays dormant
	assign ev_fire = ev_raw & (route | inten);

	// per flag register write decode
	always @* begin
		flag_wr_mask = 6'h00;
		flag_wr_set = 6'h00;
		if (wr) begin
			if (paddr == `OFS_INCREMENT_FLAG) begin
				flag_wr_mask[0] = 1'b1;
			end else if (paddr == `OFS_WRAP_FLAG) begin
				flag_wr_mask[1] = 1'b1;
			end else if (paddr == `OFS_MATCH0_FLAG) begin
				flag_wr_mask[2] = 1'b1;
			end else if (paddr == `OFS_MATCH1_FLAG) begin
				flag_wr_mask[3] = 1'b1;
			end else if (paddr == `OFS_MATCH2_FLAG) begin
				flag_wr_mask[4] = 1'b1;
			end else if (paddr == `OFS_MATCH3_FLAG) begin
				flag_wr_mask[5] = 1'b1;
			end
		end
		flag_wr_set = flag_wr_mask & {6{pwdata[0]}};
	end

	// sticky flags; hardware set beats a software clear
	always @(posedge clock) begin
		if (!rst_n) begin
			flags <= 6'h00;
		end else begin
			flags <= (flags & ~flag_wr_mask) | flag_wr_set | ev_fire;
		end
	end

	// enables, routing mask, divider and match registers
	always @(posedge clock) begin
		if (!rst_n) begin
			inten <= 6'h00;
			route <= 6'h00;
			reload <= `RESET_DIVIDER;
			for (i = 0; i < 4; i = i + 1) begin
				match_value[i] <= `RESET_COUNT;
			end
		end else if (wr) begin
			if (paddr == `OFS_IRQ_SET) begin
				inten <= inten | pick_events(pwdata);
			end else if (paddr == `OFS_IRQ_CLEAR) begin
				inten <= inten & ~pick_events(pwdata);
			end else if (paddr == `OFS_ROUTE) begin
				route <= pick_events(pwdata);
			end else if (paddr == `OFS_ROUTE_SET) begin
				route <= route | pick_events(pwdata);
			end else if (paddr == `OFS_ROUTE_CLEAR) begin
				route <= route & ~pick_events(pwdata);
			end else if (paddr == `OFS_DIVIDER) begin
				if (!running && !pend[TASK_GO]) begin
					reload <= pwdata[11:0];
				end
			end else if (paddr == `OFS_MATCH0) begin
				// new value takes effect next cycle
				match_value[0] <= pwdata[23:0];
			end else if (paddr == `OFS_MATCH1) begin
				match_value[1] <= pwdata[23:0];
			end else if (paddr == `OFS_MATCH2) begin
				match_value[2] <= pwdata[23:0];
			end else if (paddr == `OFS_MATCH3) begin
				match_value[3] <= pwdata[23:0];
			end
		end
	end

	// read multiplexer for all registers except the count
	always @* begin
		rd_word = `RESET_WORD;
		if (paddr == `OFS_INCREMENT_FLAG) begin
			rd_word[0] = flags[0];
		end else if (paddr == `OFS_WRAP_FLAG) begin
			rd_word[0] = flags[1];
		end else if (paddr == `OFS_MATCH0_FLAG) begin
			rd_word[0] = flags[2];
		end else if (paddr == `OFS_MATCH1_FLAG) begin
			rd_word[0] = flags[3];
		end else if (paddr == `OFS_MATCH2_FLAG) begin
			rd_word[0] = flags[4];
		end else if (paddr == `OFS_MATCH3_FLAG) begin
			rd_word[0] = flags[5];
		end else if (paddr == `OFS_IRQ_SET || paddr == `OFS_IRQ_CLEAR) begin
			rd_word = place_events(inten);
		end else if (paddr == `OFS_ROUTE || paddr == `OFS_ROUTE_SET ||
			paddr == `OFS_ROUTE_CLEAR) begin
			rd_word = place_events(route);
		end else if (paddr == `OFS_DIVIDER) begin
			rd_word[11:0] = reload;
		end else if (paddr == `OFS_MATCH0) begin
			rd_word[23:0] = match_value[0];
		end else if (paddr == `OFS_MATCH1) begin
			rd_word[23:0] = match_value[1];
		end else if (paddr == `OFS_MATCH2) begin
			rd_word[23:0] = match_value[2];
		end else if (paddr == `OFS_MATCH3) begin
			rd_word[23:0] = match_value[3];
		end
		// triggers and unmapped offsets read as zero
	end

	// wait state counter for count reads
	always @(posedge clock) begin
		if (!rst_n) begin
			stall <= 2'h0;
		end else if (count_read && stall != `COUNT_READ_STALL) begin
			stall <= stall + 2'h1;
		end else begin
			stall <= 2'h0;
		end
	end

	// read data register; the count is sampled late, at the end of the third wait
	// state, so a step taking effect from that edge on is not reflected in the result
	always @(posedge clock) begin
		if (!rst_n) begin
			prdata <= `RESET_WORD;
		end else if (setup & ~pwrite) begin
			prdata <= rd_word;
		end else if (count_read && stall == 2'h2) begin
			prdata <= {8'h00, count};
		end
	end

	// outputs toward the system, all from flip-flops
	always @(posedge clock) begin
		if (!rst_n) begin
			irq <= 1'b0;
			event_out <= 6'h00;
			fast_clock_request <= 1'b0;
			slow_clock_request <= 1'b0;
		end else begin
			irq <= |(flags & inten);
			event_out <= ev_raw & route;
			fast_clock_request <= |ev_fire;
			slow_clock_request <= running | (|pend);
		end
	end

endmodule

//--- tb/tick_cpu.sv
// cpu model that drives the counter's register bus
`timescale 1ns/100ps

module tick_cpu (
	input wire clock,
	input wire [31:0] prdata,
	input wire pready,
	output reg psel,
	output reg penable,
	output reg pwrite,
	output reg [11:0] paddr,
	output reg [31:0] pwdata
);
	integer hangs; // transfers whose pready never came

	// bus idle at time zero
	initial begin
		hangs = 0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end

	// one transfer; request held until pready is seen high
	task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q);
		integer n;
		begin
			n = 0;
			@(posedge clock) #1;
			psel = 1'b1;
			pwrite = w;
			paddr = a;
			pwdata = d;
			@(posedge clock) #1;
			penable = 1'b1;
			#1;
			// count reads stretch the access phase
			while (pready !== 1'b1 && n < 20) begin
				n = n + 1;
				@(posedge clock) #2;
			end
			// a stuck pready is a failure, counted by the bench
			if (n >= 20) begin
				hangs = hangs + 1;
			end
			q = prdata;
			@(posedge clock) #1;
			psel = 1'b0;
			penable = 1'b0;
			// released data must not look valid
			pwdata = ~d;
		end
	endtask
endmodule

//--- tb/low_power_tick_counter_chk.sv
// port assertions for the tick counter
`timescale 1ns/100ps
`include "low_power_tick_counter_map.vh"

module low_power_tick_counter_chk (
	input wire clock,
	input wire rst_n,
	input wire slow_clock,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire irq,
	input wire [5:0] event_out,
	input wire fast_clock_request,
	input wire slow_clock_request
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_count_stall: assert property (
		psel && !penable && !pwrite && paddr == `OFS_COUNT
		|=> !pready [*3] ##1 pready) else $error("count stall wrong");
	a_plain_ready: assert property (
		psel && penable && paddr != `OFS_COUNT |-> pready)
		else $error("plain access stalled");
	a_idle_ready: assert property (
		!psel |-> pready) else $error("pready low while idle");
	// reset checks must run during reset itself
	a_reset_quiet: assert property (disable iff (1'b0)
		!rst_n |=> event_out == 6'h00 && !irq)
		else $error("events or irq during reset");
	a_reset_req: assert property (disable iff (1'b0)
		!rst_n |=> !fast_clock_request && !slow_clock_request)
		else $error("clock request during reset");
	a_tick_gap: assert property (
		$rose(event_out[0]) |=> !event_out[0] [*8])
		else $error("increments too close");
	a_event_wake: assert property (
		event_out != 6'h00 |-> fast_clock_request)
		else $error("routed event without fast request");
	a_wake_pulse: assert property (
		fast_clock_request |=> !fast_clock_request)
		else $error("fast request not a pulse");

	c_count_read: cover property (!pready ##1 pready);
	c_wrap: cover property (event_out[1]);
	c_irq: cover property ($rose(irq));
endmodule

//--- tb/low_power_tick_counter_test.sv
// self-checking bench for the tick counter
`timescale 1ns/100ps
`include "low_power_tick_counter_map.vh"

module low_power_tick_counter_test;
	// rising slow edge every 80 bus cycles keeps the run short
	localparam integer SLOW_CYC = 80;
	reg clock;
	reg rst_n;
	reg slow_clock;
	wire psel, penable, pwrite, pready, irq;
	wire fast_clock_request, slow_clock_request;
	wire [11:0] paddr;
	wire [31:0] pwdata, prdata;
	wire [5:0] event_out;
	integer errors;
	integer checks_done;
	time t0;

	low_power_tick_counter dut (.clock(clock), .rst_n(rst_n),
		.slow_clock(slow_clock), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .irq(irq),
		.event_out(event_out), .fast_clock_request(fast_clock_request),
		.slow_clock_request(slow_clock_request));

	tick_cpu cpu (.clock(clock), .prdata(prdata), .pready(pready),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata));

	// bus clock, 5 ns period
	always #2.5 clock = ~clock;

	initial begin
		slow_clock = 1'b0;
		#1.3;
		forever #200 slow_clock = ~slow_clock;
	end

	task chk(input [31:0] seen, input [31:0] want);
		begin
			checks_done = checks_done + 1;
			if (seen !== want) begin
				errors = errors + 1;
				$display("BAD %0t seen %h want %h", $time, seen, want);
			end
		end
	endtask

	task wr(input [11:0] a, input [31:0] d);
		reg [31:0] q;
		cpu.xfer(1'b1, a, d, q);
	endtask

	task rdc(input [11:0] a, input [31:0] want);
		reg [31:0] q;
		begin
			cpu.xfer(1'b0, a, 32'h0000_0000, q);
			chk(q, want);
		end
	endtask

	// wait for an event pulse, bounded
	task wait_ev(input integer b);
		integer n;
		begin
			n = 0;
			while (event_out[b] !== 1'b1 && n < 4000) begin
				n = n + 1;
				@(posedge clock) #1;
			end
			chk(n < 4000, 1);
		end
	endtask

	task final_report;
		begin
			// bus transfers that timed out count as mismatches
			errors = errors + cpu.hangs;
			$display("errors %0d checks %0d", errors, checks_done);
			if (errors == 0 && checks_done > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask

	// watchdog at 20k cycles, over four times the expected run
	initial begin
		#100000;
		errors = errors + 1;
		final_report;
	end

	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		errors = 0;
		checks_done = 0;
		repeat (4) @(posedge clock);
		#1 rst_n = 1'b1;
		rdc(`OFS_DIVIDER, 0);
		rdc(`OFS_ROUTE, 0);
		rdc(`OFS_IRQ_SET, 0);
		rdc(`OFS_COUNT, 0);
		rdc(12'h7f0, 0);
		wr(`OFS_DIVIDER, 1);
		rdc(`OFS_DIVIDER, 1);
		wr(`OFS_ROUTE_SET, 3);
		rdc(`OFS_ROUTE, 3);
		wr(`OFS_IRQ_SET, 32'h0001_0000);
		rdc(`OFS_IRQ_CLEAR, 32'h0001_0000);
		wr(`OFS_MATCH0, 3);
		wr(`OFS_GO_TRIGGER, 1);
		wait_ev(0);
		chk(slow_clock_request, 1);
		t0 = $time;
		@(posedge clock) #1;
		wait_ev(0);
		chk(($time - t0) / 5, 2 * SLOW_CYC);
		wr(`OFS_DIVIDER, 5);
		rdc(`OFS_DIVIDER, 1);
		@(posedge clock) #1;
		wait_ev(0);
		rdc(`OFS_COUNT, 3);
		rdc(`OFS_MATCH0_FLAG, 1);
		chk(irq, 1);
		wr(`OFS_MATCH0_FLAG, 0);
		rdc(`OFS_MATCH0_FLAG, 0);
		chk(irq, 0);
		// preset lands before the next step is due
		wr(`OFS_PRESET_TRIGGER, 1);
		repeat (140) @(posedge clock);
		rdc(`OFS_COUNT, 32'h00ff_fff0);
		wait_ev(1);
		rdc(`OFS_COUNT, 0);
		rdc(`OFS_WRAP_FLAG, 1);
		wr(`OFS_MATCH0, 0);
		wr(`OFS_HALT_TRIGGER, 1);
		repeat (300) @(posedge clock);
		// halted before the step after the wrap, count stays zero
		rdc(`OFS_COUNT, 0);
		repeat (400) @(posedge clock);
		rdc(`OFS_COUNT, 0);
		// preset while stopped raises the slow clock request
		wr(`OFS_PRESET_TRIGGER, 1);
		@(posedge clock) #1;
		chk(slow_clock_request, 1);
		repeat (200) @(posedge clock);
		rdc(`OFS_COUNT, 32'h00ff_fff0);
		// clear from a nonzero count with match value zero armed
		wr(`OFS_ZERO_TRIGGER, 1);
		repeat (300) @(posedge clock);
		rdc(`OFS_COUNT, 0);
		rdc(`OFS_MATCH0_FLAG, 0);
		final_report;
	end
endmodule

bind low_power_tick_counter low_power_tick_counter_chk chk (
	.clock(clock), .rst_n(rst_n), .slow_clock(slow_clock), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .irq(irq), .event_out(event_out),
	.fast_clock_request(fast_clock_request),
	.slow_clock_request(slow_clock_request));
